// *** hw/llmc_regs.svh ***
/*
 * Timing constants for the line, local and motor control block.
 * Assumes a 100 MHz system clock.
 */
`ifndef LLMC_REGS_SVH
`define LLMC_REGS_SVH

`define LLMC_CLK_HZ          100000000
`define LLMC_TICK_HZ         1000
`define LLMC_TICK_CYCLES     (`LLMC_CLK_HZ / `LLMC_TICK_HZ)
`define LLMC_FILTER_MS       20
`define LLMC_LOCAL_REL_MS    2300
`define LLMC_MOTOR_HOLD_MS   550
`define LLMC_MOTOR_MIN_MS    475
`define LLMC_MOTOR_MAX_MS    675

`endif

// *** hw/llmc_pkg.sv ***
/*
 * Types for the line, local and motor control block.
 * Assumes nothing of its surroundings.
 */
package llmc_pkg;
    typedef enum logic [1:0] {
        LLMC_POL_NEUTRAL,
        LLMC_POL_POS,
        LLMC_POL_NEG
    } llmc_pol_t;
endpackage

// *** hw/llmc_tick_if.sv ***
/*
 * Interface carrying the millisecond tick between the divider and the control logic.
 * Assumes a single clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

interface llmc_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input  tick);
endinterface // llmc_tick_if

`default_nettype wire

// *** hw/llmc_tick_gen.sv ***
/*
 * Divider producing a one-cycle tick enable from the system clock.
 * Assumes clk_in is the only clock; reset is asynchronous, active low.
 */
`timescale 1ns/1ps
`default_nettype none
`include "llmc_regs.svh"

module llmc_tick_gen #(
    parameter int TICK_CYCLES = `LLMC_TICK_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    llmc_tick_if.src  tick_out
);
    localparam int CW = $clog2(TICK_CYCLES + 1);

    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("TICK_CYCLES must be at least 2");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } llmc_div_t;

    llmc_div_t state_reg;
    llmc_div_t state_next;

    always_comb begin
        state_next      = state_reg;
        state_next.tick = 1'b0;
        if (state_reg.cnt == CW'(TICK_CYCLES - 1)) begin
            state_next.cnt  = '0;
            state_next.tick = 1'b1;
        end else begin
            state_next.cnt = state_reg.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tick_out.tick = state_reg.tick;
endmodule // llmc_tick_gen

`default_nettype wire

// *** hw/llmc_top.sv ***
/*
 * Connect, local and motor-hold control for a terminal line connection.
 * Assumes pins are asynchronous to clk_in and buttons are debounced
 * mechanically; the proceed-to-dial state comes from logic on clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
`include "llmc_regs.svh"

// Notes on behaviour
// - Connect follows line, filtered 20 ms, gated by low paper
// - Positive polarity sets connect
// - Negative polarity clears connect
// - Neutral line leaves connect unchanged
// - Low paper blocks connecting, not disconnecting
// - Local button works only when disconnected and not in dial state
// - Start or stop clears local
// - Release timer held at zero while disconnected
// - After 2.3 s connected, pulse clears local
// - Release pulse repeats while connected
// - Motor hold input is connect or local
// - Motor turns on immediately
// - Motor stays on 0.55 s after drop
// - Motor delay within 0.475 to 0.675 s
module llmc_top #(
    parameter int TICK_CYCLES  = `LLMC_TICK_CYCLES,
    parameter int FILTER_TICKS = `LLMC_FILTER_MS,
    parameter int LOCAL_TICKS  = `LLMC_LOCAL_REL_MS,
    parameter int MOTOR_TICKS  = `LLMC_MOTOR_HOLD_MS
) (
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    input  wire logic line_pos_in,
    input  wire logic line_neg_in,
    input  wire logic low_paper_in,
    input  wire logic local_btn_in,
    input  wire logic start_btn_in,
    input  wire logic stop_btn_in,
    input  wire logic dial_state_in,
    output var  logic connect_out,
    output var  logic local_out,
    output var  logic motor_out,
    output var  logic release_pulse_out
);
    localparam int FW = $clog2(FILTER_TICKS + 1);
    localparam int LW = $clog2(LOCAL_TICKS + 1);
    localparam int MW = $clog2(MOTOR_TICKS + 1);

    // ========================================================
    // Parameter checks
    // ========================================================
    if (FILTER_TICKS < 1 || LOCAL_TICKS < 1 || MOTOR_TICKS < 1) begin : g_bad_counts
        $error("Timer counts must be at least 1");
    end
    if (TICK_CYCLES == `LLMC_TICK_CYCLES &&
        (MOTOR_TICKS < `LLMC_MOTOR_MIN_MS || MOTOR_TICKS > `LLMC_MOTOR_MAX_MS)) begin : g_bad_motor
        $error("Motor hold delay outside permitted range");
    end

    // ========================================================
    // Tick divider
    // ========================================================
    llmc_tick_if tick_bus ();

    llmc_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .tick_out   (tick_bus)
    );

    // ========================================================
    // State
    // ========================================================
    typedef struct packed {
        logic [2:0]    pos_sync;
        logic [2:0]    neg_sync;
        logic [2:0]    paper_sync;
        logic [2:0]    lcl_sync;
        logic [2:0]    start_sync;
        logic [2:0]    stop_sync;
        logic          pos_st;
        logic          neg_st;
        logic          paper_st;
        logic          lcl_st;
        logic          start_st;
        logic          stop_st;
        logic [1:0]    pol_cand;
        logic [1:0]    pol_filt;
        logic [FW-1:0] filt_cnt;
        logic          connect;
        logic          local_on;
        logic [LW-1:0] rel_cnt;
        logic          rel_pulse;
        logic          motor;
        logic [MW-1:0] motor_cnt;
    } llmc_state_t;

    llmc_state_t state_reg;
    llmc_state_t state_next;

    llmc_pkg::llmc_pol_t pol_raw;
    logic                hold_in;

    always_comb begin
        state_next = state_reg;
        state_next.rel_pulse = 1'b0;

        // Three-stage synchronisers, steady value updates only when sync bits 2 and 1 agree
        state_next.pos_sync   = {state_reg.pos_sync[1:0],   line_pos_in};
        state_next.neg_sync   = {state_reg.neg_sync[1:0],   line_neg_in};
        state_next.paper_sync = {state_reg.paper_sync[1:0], low_paper_in};
        state_next.lcl_sync   = {state_reg.lcl_sync[1:0],   local_btn_in};
        state_next.start_sync = {state_reg.start_sync[1:0], start_btn_in};
        state_next.stop_sync  = {state_reg.stop_sync[1:0],  stop_btn_in};
        if (state_reg.pos_sync[2] == state_reg.pos_sync[1]) begin
            state_next.pos_st = state_reg.pos_sync[2];
        end
        if (state_reg.neg_sync[2] == state_reg.neg_sync[1]) begin
            state_next.neg_st = state_reg.neg_sync[2];
        end
        if (state_reg.paper_sync[2] == state_reg.paper_sync[1]) begin
            state_next.paper_st = state_reg.paper_sync[2];
        end
        if (state_reg.lcl_sync[2] == state_reg.lcl_sync[1]) begin
            state_next.lcl_st = state_reg.lcl_sync[2];
        end
        if (state_reg.start_sync[2] == state_reg.start_sync[1]) begin
            state_next.start_st = state_reg.start_sync[2];
        end
        if (state_reg.stop_sync[2] == state_reg.stop_sync[1]) begin
            state_next.stop_st = state_reg.stop_sync[2];
        end

        // Both or neither polarity reads as neutral
        if (state_reg.pos_st && !state_reg.neg_st) begin
            pol_raw = llmc_pkg::LLMC_POL_POS;
        end else if (state_reg.neg_st && !state_reg.pos_st) begin
            pol_raw = llmc_pkg::LLMC_POL_NEG;
        end else begin
            pol_raw = llmc_pkg::LLMC_POL_NEUTRAL;
        end

        if (pol_raw != llmc_pkg::llmc_pol_t'(state_reg.pol_cand)) begin
            state_next.pol_cand = pol_raw;
            state_next.filt_cnt = '0;
        end else if (state_reg.pol_filt != state_reg.pol_cand && tick_bus.tick) begin
            if (state_reg.filt_cnt == FW'(FILTER_TICKS - 1)) begin
                state_next.pol_filt = state_reg.pol_cand;
            end else begin
                state_next.filt_cnt = state_reg.filt_cnt + FW'(1);
            end
        end

        if (state_reg.pol_filt == 2'(llmc_pkg::LLMC_POL_POS) && !state_reg.paper_st) begin
            state_next.connect = 1'b1;
        end
        if (state_reg.pol_filt == 2'(llmc_pkg::LLMC_POL_NEG)) begin
            state_next.connect = 1'b0;
        end

        if (!state_reg.connect) begin
            state_next.rel_cnt = '0;
        end else if (tick_bus.tick) begin
            if (state_reg.rel_cnt == LW'(LOCAL_TICKS - 1)) begin
                state_next.rel_cnt   = '0;
                state_next.rel_pulse = 1'b1;
            end else begin
                state_next.rel_cnt = state_reg.rel_cnt + LW'(1);
            end
        end

        if (state_reg.lcl_st && !dial_state_in && !state_reg.connect) begin
            state_next.local_on = 1'b1;
        end
        if (state_reg.start_st || state_reg.stop_st || state_reg.rel_pulse) begin
            state_next.local_on = 1'b0;
        end

        hold_in = state_reg.connect || state_reg.local_on;

        if (hold_in) begin
            state_next.motor     = 1'b1;
            state_next.motor_cnt = '0;
        end else if (state_reg.motor && tick_bus.tick) begin
            if (state_reg.motor_cnt == MW'(MOTOR_TICKS - 1)) begin
                state_next.motor     = 1'b0;
                state_next.motor_cnt = '0;
            end else begin
                state_next.motor_cnt = state_reg.motor_cnt + MW'(1);
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign connect_out       = state_reg.connect;
    assign local_out         = state_reg.local_on;
    assign motor_out         = state_reg.motor;
    assign release_pulse_out = state_reg.rel_pulse;
endmodule // llmc_top

`default_nettype wire

// *** tb/llmc_exchange_model.sv ***
/* Exchange model: drives the loop polarity as two level pins.
   Assumes the bench picks the polarity; pins change on clk_in. */
`timescale 1ns/1ps
`default_nettype none
module llmc_exchange_model (
    input  wire logic                clk_in,
    input  wire llmc_pkg::llmc_pol_t pol_in,
    output var  logic                line_pos_out,
    output var  logic                line_neg_out
);
    // Reversal reaches the pins at a clock edge
    always_ff @(posedge clk_in) begin
        line_pos_out <= (pol_in == llmc_pkg::LLMC_POL_POS);
        line_neg_out <= (pol_in == llmc_pkg::LLMC_POL_NEG);
    end
endmodule // llmc_exchange_model
`default_nettype wire

// *** tb/llmc_top_asserts.sv ***
/* Port checker for llmc_top.
   Bound to every llmc_top; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module llmc_top_asserts #(
    parameter int TICK_CYCLES  = 10,
    parameter int FILTER_TICKS = 2,
    parameter int LOCAL_TICKS  = 5,
    parameter int MOTOR_TICKS  = 4
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic line_pos_in,
    input wire logic line_neg_in,
    input wire logic low_paper_in,
    input wire logic dial_state_in,
    input wire logic connect_out,
    input wire logic local_out,
    input wire logic motor_out,
    input wire logic release_pulse_out
);
    localparam int MLO = (MOTOR_TICKS - 1) * TICK_CYCLES;
    localparam int MHI = (MOTOR_TICKS + 1) * TICK_CYCLES + 8;
    localparam int FLO = (FILTER_TICKS - 1) * TICK_CYCLES;
    int idle_cnt;
    int pos_cnt;
    int neg_cnt;
    // ========================================
    // Cycles since hold input low, line steady
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            idle_cnt <= 0;
            pos_cnt  <= 0;
            neg_cnt  <= 0;
        end else begin
            idle_cnt <= (connect_out || local_out) ? 0 : (idle_cnt < 5000) ? idle_cnt + 1 : idle_cnt;
            pos_cnt  <= (line_pos_in && !line_neg_in) ? pos_cnt + 1 : 0;
            neg_cnt  <= (line_neg_in && !line_pos_in) ? neg_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // ========================================
    // Properties
    a_motor_on: assert property ((connect_out || local_out) |=> motor_out) else $error("motor off");
    a_motor_min: assert property ($fell(motor_out) |-> idle_cnt >= MLO) else $error("motor short");
    a_motor_max: assert property (motor_out |-> idle_cnt <= MHI) else $error("motor long");
    a_conn_set: assert property ($rose(connect_out) |-> pos_cnt >= FLO && !low_paper_in) else $error("set");
    a_conn_clear: assert property ($fell(connect_out) |-> neg_cnt >= FLO) else $error("clear");
    a_local_gate: assert property ($rose(local_out) |-> !$past(connect_out) && !$past(dial_state_in))
        else $error("local gate");
    a_release_clears: assert property (release_pulse_out |=> !local_out) else $error("local kept");
    a_release_conn: assert property (release_pulse_out |-> connect_out || $past(connect_out))
        else $error("pulse idle");
    a_release_single: assert property (release_pulse_out |=> !release_pulse_out) else $error("pulse wide");
endmodule // llmc_top_asserts
bind llmc_top llmc_top_asserts #(.TICK_CYCLES(TICK_CYCLES), .FILTER_TICKS(FILTER_TICKS),
    .LOCAL_TICKS(LOCAL_TICKS), .MOTOR_TICKS(MOTOR_TICKS)) llmc_top_asserts_inst (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .line_pos_in(line_pos_in), .line_neg_in(line_neg_in), .low_paper_in(low_paper_in),
    .dial_state_in(dial_state_in), .connect_out(connect_out), .local_out(local_out), .motor_out(motor_out),
    .release_pulse_out(release_pulse_out));
`default_nettype wire

// *** tb/tb_llmc_top.sv ***
/* Self-checking bench for llmc_top, short timing parameters.
   Assumes exchange model and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_llmc_top;
    localparam int TC = 10;
    localparam int FT = 2;
    localparam int LT = 5;
    localparam int MT = 4;
    logic                clk_in        = 1'h0;
    logic                reset_n_in    = 1'h0;
    logic                low_paper_in  = 1'h0;
    logic                local_btn_in  = 1'h0;
    logic                start_btn_in  = 1'h0;
    logic                stop_btn_in   = 1'h0;
    logic                dial_state_in = 1'h0;
    llmc_pkg::llmc_pol_t pol           = llmc_pkg::LLMC_POL_NEG;
    logic                line_pos;
    logic                line_neg;
    logic                connect_out;
    logic                local_out;
    logic                motor_out;
    logic                release_pulse_out;
    int                  errors        = 0;
    int                  checks_done   = 0;
    int                  n;
    llmc_exchange_model llmc_exchange_model_inst (.clk_in(clk_in), .pol_in(pol), .line_pos_out(line_pos),
        .line_neg_out(line_neg));
    llmc_top #(.TICK_CYCLES(TC), .FILTER_TICKS(FT), .LOCAL_TICKS(LT), .MOTOR_TICKS(MT)) llmc_top_inst (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .line_pos_in(line_pos), .line_neg_in(line_neg),
        .low_paper_in(low_paper_in), .local_btn_in(local_btn_in), .start_btn_in(start_btn_in),
        .stop_btn_in(stop_btn_in), .dial_state_in(dial_state_in), .connect_out(connect_out),
        .local_out(local_out), .motor_out(motor_out), .release_pulse_out(release_pulse_out));
    initial forever #5 clk_in = ~clk_in;
    // ========================================
    // Drivers
    task automatic step(input int c);
        repeat (c) @(posedge clk_in);
        #1;
    endtask
    // Button 2 local, 1 start, 0 stop
    task automatic btn(input int w);
        {local_btn_in, start_btn_in, stop_btn_in} = 3'(1 << w);
        step(8);
        {local_btn_in, start_btn_in, stop_btn_in} = 3'h0;
        step(8);
    endtask
    function automatic logic sel(input int w);
        return (w == 0) ? connect_out : (w == 1) ? motor_out : release_pulse_out;
    endfunction
    task automatic wait_for(input int w, input logic v);
        n = 0;
        while (sel(w) !== v && n < 500) begin
            step(1);
            n++;
        end
    endtask
    // ========================================
    // Scenarios
    task automatic t_local();
        `CHK({connect_out, local_out, motor_out, release_pulse_out}, 4'h0)
        btn(2);
        `CHK(local_out, 1'h1)
        `CHK(motor_out, 1'h1)
        btn(1);
        `CHK(local_out, 1'h0)
        `CHK(motor_out, 1'h1)
        btn(2);
        step(MT * TC + 20);
        `CHK(motor_out, 1'h1)
        btn(0);
        `CHK(local_out, 1'h0)
        wait_for(1, 1'h0);
        `CHK(n >= (MT - 1) * TC - 12 && n <= (MT + 1) * TC, 1'h1)
    endtask
    task automatic t_paper();
        dial_state_in = 1'h1;
        btn(2);
        `CHK(local_out, 1'h0)
        dial_state_in = 1'h0;
        low_paper_in  = 1'h1;
        pol           = llmc_pkg::LLMC_POL_POS;
        step(FT * TC * 3);
        `CHK(connect_out, 1'h0)
        low_paper_in = 1'h0;
        wait_for(0, 1'h1);
        `CHK(connect_out, 1'h1)
        btn(2);
        `CHK(local_out, 1'h0)
        low_paper_in = 1'h1;
        pol          = llmc_pkg::LLMC_POL_NEUTRAL;
        step(FT * TC * 3);
        `CHK(connect_out, 1'h1)
        pol = llmc_pkg::LLMC_POL_NEG;
        wait_for(0, 1'h0);
        `CHK(connect_out, 1'h0)
        low_paper_in = 1'h0;
        wait_for(1, 1'h0);
    endtask
    task automatic t_release();
        btn(2);
        pol = llmc_pkg::LLMC_POL_POS;
        wait_for(0, 1'h1);
        `CHK(n >= (FT - 1) * TC, 1'h1)
        wait_for(2, 1'h1);
        `CHK(n >= (LT - 1) * TC && n <= (LT + 1) * TC, 1'h1)
        step(1);
        `CHK(local_out, 1'h0)
        wait_for(2, 1'h1);
        `CHK(n >= (LT - 1) * TC - 1 && n <= (LT + 1) * TC, 1'h1)
        pol = llmc_pkg::LLMC_POL_NEG;
        wait_for(0, 1'h0);
        wait_for(1, 1'h0);
    endtask
    task automatic t_reset();
        pol = llmc_pkg::LLMC_POL_POS;
        wait_for(0, 1'h1);
        reset_n_in = 1'h0;
        step(2);
        `CHK({connect_out, local_out, motor_out, release_pulse_out}, 4'h0)
        reset_n_in = 1'h1;
        step(2);
        `CHK({connect_out, motor_out}, 2'h0)
        wait_for(0, 1'h1);
        `CHK(connect_out, 1'h1)
        pol = llmc_pkg::LLMC_POL_NEG;
        wait_for(0, 1'h0);
        `CHK(connect_out, 1'h0)
        wait_for(1, 1'h0);
    endtask
    task automatic complete_run();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_in);
        #1;
        reset_n_in = 1'h1;
        step(1);
        t_local();
        t_paper();
        t_release();
        t_reset();
        complete_run();
    end
    initial begin
        #100000;
        errors++;
        complete_run();
    end
endmodule // tb_llmc_top
`default_nettype wire
